// ### pkg/mvd_pkg.sv
// Package: constants and carrier types of the unsigned dot-accumulate unit
package mvd_pkg;
  // Vector geometry
  localparam int VL_DEF   = 128;
  localparam int ACC_DIV  = 8;
  localparam int SEG_BITS = 128;
  localparam int B8       = 8;
  localparam int H16      = 16;
  localparam int E32      = 32;
  localparam int E64      = 64;
  localparam int WAY2     = 2;
  localparam int WAY4     = 4;
  localparam int SEG32    = SEG_BITS / E32;
  localparam int SEG64    = SEG_BITS / E64;
  localparam logic [2:0] VSEL_PREFIX = 3'h2;

  // Register map, byte addresses
  localparam int AW = 8;
  localparam logic [AW-1:0] OFF_CTRL = 8'h00;
  localparam logic [AW-1:0] OFF_STAT = 8'h04;
  localparam logic [AW-1:0] OFF_RSEL = 8'h08;
  localparam logic [AW-1:0] OFF_RDAT = 8'h0C;

  // Field positions and reset values
  localparam int CTRL_FEAT2 = 0;
  localparam int CTRL_WIDE  = 1;
  localparam int CTRL_STRM  = 2;
  localparam int CTRL_ZA    = 3;
  localparam int CTRL_W     = 4;
  localparam int STAT_BUSY  = 0;
  localparam int STAT_UNDEF = 1;
  localparam int STAT_TRAP  = 2;
  localparam int RSEL_WORD  = 8;
  localparam logic [CTRL_W-1:0] CTRL_RST = 4'h0;

  // Instruction forms
  typedef enum logic [1:0] {
    MVD_SINGLE = 2'h0,
    MVD_MULTI  = 2'h1,
    MVD_IDX2   = 2'h2,
    MVD_IDX4   = 2'h3
  } mvd_form_t;

  // Decoded instruction from the issue stage
  typedef struct packed {
    mvd_form_t  form;
    logic       four_grp;
    logic       sz;
    logic [4:0] zn;
    logic [3:0] zm;
    logic [1:0] rv;
    logic [2:0] vector_offset_field;
    logic [1:0] idx;
  } mvd_cmd_t;

  // Operand fetch request
  typedef struct packed {
    logic [4:0] n_idx;
    logic [4:0] m_idx;
    logic [4:0] gpr_idx;
  } mvd_src_t;
endpackage

// ### hdl/mvd_dot_acc.sv
// Unsigned multi-vector dot product accumulating into the accumulator array
// Operation
// - 2-way: two 16-bit products summed per element
// - Sum added into accumulator element, written back
// - Start vector: select plus offset, modulo stride
// - Select register number is 010 plus field
// - Offset is unsigned three-bit field, 0..7
// - Single form: first sources consecutive, wrap 32
// - Single form: second source within registers 0..15
// - Multi form: first group aligned to 2/4
// - Multi form: second group aligned, member-paired
// - Qualifier selects two or four groups
// - Vectors = VL/8; stride = vectors/groups
// - Advance vector index by stride per register
// - Elements per vector = VL/element size
// - 4-way: four 8/16-bit products summed
// - Index picks same element per 128-bit segment
// - Index one bit for 64, two for 32
// - Undefined without second-version matrix feature
// - 64-bit indexed needs wide integer feature
//
// Decided for this implementation: the APB register port and the register offsets.
`timescale 1ns/100ps
module mvd_dot_acc #(
  parameter int VL = mvd_pkg::VL_DEF
) (
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  reset,
  // APB slave
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [mvd_pkg::AW-1:0] paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  // Issue port
  input  wire logic                  cmd_valid,
  input  wire mvd_pkg::mvd_cmd_t     cmd,
  output logic                       cmd_ready,
  // Operand fetch
  output logic                       src_valid,
  output mvd_pkg::mvd_src_t          src,
  input  wire logic                  src_ack,
  input  wire logic [VL-1:0]         src_op1,
  input  wire logic [VL-1:0]         src_op2,
  input  wire logic [31:0]           src_wv,
  // Completion events
  output logic                       done,
  output logic                       undef,
  output logic                       trap
);
  import mvd_pkg::*;

  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam int VECS = VL / ACC_DIV;
  localparam int VW   = $clog2(VECS);
  localparam int E32N = VL / E32;
  localparam int E64N = VL / E64;
  localparam int WDW  = $clog2(E32N);
  localparam logic [VW-1:0] STR2 = VW'(VECS / WAY2);
  localparam logic [VW-1:0] STR4 = VW'(VECS / WAY4);

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b01,
    ST_FETCH = 2'b10
  } mvd_state_t;

  mvd_state_t         state_reg;
  mvd_cmd_t           cmd_reg;
  logic [1:0]         r_reg;
  logic [VW-1:0]      vec_reg;
  logic [VL-1:0]      za_reg [VECS];
  logic [CTRL_W-1:0]  ctrl_reg;
  logic               undef_st_reg;
  logic               trap_st_reg;
  logic [31:0]        rsel_reg;
  logic               cmd_ready_reg;
  logic               src_valid_reg;
  mvd_src_t           src_reg;
  logic               done_reg;
  logic               undef_reg;
  logic               trap_reg;
  logic [31:0]        prdata_reg;
  logic               pready_reg;
  logic               pslverr_reg;

  logic               accept;
  logic               take;
  logic               bad_feat;
  logic               bad_en;
  logic [1:0]         last_r;
  logic [VW-1:0]      vstride;
  logic [VW-1:0]      vec0;
  logic [VW-1:0]      cur_vec;
  logic [VL-1:0]      acc_cur;
  logic [VL-1:0]      acc_new;

  // ----------------------------------------------------------------
  // Decode and checks
  // ----------------------------------------------------------------
  assign accept   = cmd_valid && cmd_ready_reg;
  assign take     = src_valid_reg && src_ack;
  // Feature gates come first, so an unsupported form never traps
  assign bad_feat = !ctrl_reg[CTRL_FEAT2] ||
                    (cmd.form == MVD_IDX4 && cmd.sz && !ctrl_reg[CTRL_WIDE]);
  assign bad_en   = !(ctrl_reg[CTRL_STRM] && ctrl_reg[CTRL_ZA]);
  assign last_r   = cmd_reg.four_grp ? 2'h3 : 2'h1;
  assign vstride  = cmd_reg.four_grp ? STR4 : STR2;
  // Stride is a power of two, so the modulo is a mask
  assign vec0     = VW'(src_wv + 32'(cmd_reg.vector_offset_field)) & (vstride - 1'b1);
  assign cur_vec  = (r_reg == 2'h0) ? vec0 : vec_reg;
  assign acc_cur  = za_reg[cur_vec];

  // Source register numbers for group member r
  function automatic mvd_src_t src_for(mvd_cmd_t c, logic [1:0] r);
    mvd_src_t s;
    s.gpr_idx = {VSEL_PREFIX, c.rv};
    s.n_idx   = 5'h00;
    s.m_idx   = 5'h00;
    case (c.form)
      MVD_SINGLE: begin
        s.n_idx = c.zn + {3'h0, r}; // wraps at 32
        s.m_idx = {1'b0, c.zm};
      end
      MVD_MULTI: begin
        if (c.four_grp) begin
          s.n_idx = {c.zn[2:0], r};
          s.m_idx = {c.zm[2:0], r};
        end else begin
          s.n_idx = {c.zn[3:0], r[0]};
          s.m_idx = {c.zm[3:0], r[0]};
        end
      end
      default: begin
        s.n_idx = c.four_grp ? {c.zn[2:0], r} : {c.zn[3:0], r[0]};
        s.m_idx = {1'b0, c.zm};
      end
    endcase
    return s;
  endfunction

  // ----------------------------------------------------------------
  // Dot product datapath
  // ----------------------------------------------------------------
  // Loops cover both element sizes; only one branch is live per form and size
  always_comb begin
    logic [E64-1:0] sum;
    logic [E64-1:0] pa;
    logic [E64-1:0] pb;
    logic           idx_on;
    int             ix;
    int             s;
    sum     = '0;
    pa      = '0;
    pb      = '0;
    s       = 0;
    idx_on  = cmd_reg.form == MVD_IDX2 || cmd_reg.form == MVD_IDX4;
    ix      = cmd_reg.sz ? int'(cmd_reg.idx[0]) : int'(cmd_reg.idx);
    acc_new = acc_cur;
    if (cmd_reg.form == MVD_IDX4 && cmd_reg.sz) begin
      for (int e = 0; e < E64N; e++) begin
        s   = idx_on ? (e - (e % SEG64) + ix) : e;
        sum = acc_cur[e*E64 +: E64];
        for (int i = 0; i < WAY4; i++) begin
          pa  = E64'(src_op1[(WAY4*e+i)*H16 +: H16]);
          pb  = E64'(src_op2[(WAY4*s+i)*H16 +: H16]);
          sum = sum + pa * pb;
        end
        acc_new[e*E64 +: E64] = sum;
      end
    end else begin
      for (int e = 0; e < E32N; e++) begin
        s   = idx_on ? (e - (e % SEG32) + ix) : e;
        sum = E64'(acc_cur[e*E32 +: E32]);
        if (cmd_reg.form == MVD_IDX4) begin
          for (int i = 0; i < WAY4; i++) begin
            pa  = E64'(src_op1[(WAY4*e+i)*B8 +: B8]);
            pb  = E64'(src_op2[(WAY4*s+i)*B8 +: B8]);
            sum = sum + pa * pb;
          end
        end else begin
          for (int i = 0; i < WAY2; i++) begin
            pa  = E64'(src_op1[(WAY2*e+i)*H16 +: H16]);
            pb  = E64'(src_op2[(WAY2*s+i)*H16 +: H16]);
            sum = sum + pa * pb;
          end
        end
        acc_new[e*E32 +: E32] = sum[E32-1:0]; // wraps
      end
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  // One register of the group per granted fetch
  always_ff @(posedge clk) begin
    if (reset) begin
      state_reg     <= ST_IDLE;
      cmd_reg       <= '0;
      r_reg         <= 2'h0;
      vec_reg       <= '0;
      cmd_ready_reg <= 1'b0;
      src_valid_reg <= 1'b0;
      src_reg       <= '0;
      done_reg      <= 1'b0;
      undef_reg     <= 1'b0;
      trap_reg      <= 1'b0;
    end else begin
      done_reg  <= 1'b0;
      undef_reg <= 1'b0;
      trap_reg  <= 1'b0;
      case (state_reg)
        ST_IDLE: begin
          cmd_ready_reg <= 1'b1;
          if (accept) begin
            cmd_reg <= cmd;
            r_reg   <= 2'h0;
            if (bad_feat) begin
              undef_reg <= 1'b1;
            end else if (bad_en) begin
              trap_reg <= 1'b1;
            end else begin
              state_reg     <= ST_FETCH;
              cmd_ready_reg <= 1'b0;
              src_valid_reg <= 1'b1;
              src_reg       <= src_for(cmd, 2'h0);
            end
          end
        end
        ST_FETCH: begin
          if (take) begin
            vec_reg <= cur_vec + vstride;
            if (r_reg == last_r) begin
              state_reg     <= ST_IDLE;
              cmd_ready_reg <= 1'b1;
              src_valid_reg <= 1'b0;
              done_reg      <= 1'b1;
            end else begin
              r_reg   <= r_reg + 2'h1;
              src_reg <= src_for(cmd_reg, r_reg + 2'h1);
            end
          end
        end
        default: begin
          state_reg     <= ST_IDLE;
          src_valid_reg <= 1'b0;
        end
      endcase
    end
  end

  // Accumulator array; written once per granted fetch
  always_ff @(posedge clk) begin
    if (reset) begin
      for (int v = 0; v < VECS; v++) begin
        za_reg[v] <= '0;
      end
    end else if (take) begin
      za_reg[cur_vec] <= acc_new;
    end
  end

  // ----------------------------------------------------------------
  // APB registers
  // ----------------------------------------------------------------
  logic            setup;
  logic            wr_en;
  logic            hit;
  logic [31:0]     rd_mux;
  logic [VW-1:0]   rd_vec;
  logic [WDW-1:0]  rd_word;

  assign setup   = psel && !penable;
  assign wr_en   = psel && penable && pready_reg && pwrite && hit;
  assign hit     = paddr == OFF_CTRL || paddr == OFF_STAT ||
                   paddr == OFF_RSEL || paddr == OFF_RDAT;
  assign rd_vec  = rsel_reg[VW-1:0];
  assign rd_word = rsel_reg[RSEL_WORD +: WDW];

  // Read mux, latched in the setup cycle
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (paddr)
      OFF_CTRL: rd_mux = 32'(ctrl_reg);
      OFF_STAT: begin
        rd_mux[STAT_BUSY]  = state_reg != ST_IDLE;
        rd_mux[STAT_UNDEF] = undef_st_reg;
        rd_mux[STAT_TRAP]  = trap_st_reg;
      end
      OFF_RSEL: rd_mux = rsel_reg;
      OFF_RDAT: rd_mux = za_reg[rd_vec][rd_word*E32 +: E32];
      default:  rd_mux = 32'h0000_0000;
    endcase
  end

  // No wait state: pready rises in the first access cycle
  always_ff @(posedge clk) begin
    if (reset) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h0000_0000;
    end else begin
      pready_reg <= setup;
      if (setup) begin
        prdata_reg  <= rd_mux;
        pslverr_reg <= !hit;
      end
    end
  end

  // Control and readback select
  always_ff @(posedge clk) begin
    if (reset) begin
      ctrl_reg <= CTRL_RST;
      rsel_reg <= 32'h0000_0000;
    end else if (wr_en) begin
      if (paddr == OFF_CTRL) begin
        ctrl_reg <= pwdata[CTRL_W-1:0];
      end
      if (paddr == OFF_RSEL) begin
        rsel_reg <= pwdata;
      end
    end
  end

  // Sticky fault flags, write one to clear; a new event wins the clear
  always_ff @(posedge clk) begin
    if (reset) begin
      undef_st_reg <= 1'b0;
      trap_st_reg  <= 1'b0;
    end else begin
      undef_st_reg <= undef_reg ||
                      (undef_st_reg && !(wr_en && paddr == OFF_STAT && pwdata[STAT_UNDEF]));
      trap_st_reg  <= trap_reg ||
                      (trap_st_reg && !(wr_en && paddr == OFF_STAT && pwdata[STAT_TRAP]));
    end
  end

  // Outputs straight from flops
  assign prdata    = prdata_reg;
  assign pready    = pready_reg;
  assign pslverr   = pslverr_reg;
  assign cmd_ready = cmd_ready_reg;
  assign src_valid = src_valid_reg;
  assign src       = src_reg;
  assign done      = done_reg;
  assign undef     = undef_reg;
  assign trap      = trap_reg;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  a_undef_nofeat: assert property (accept && !ctrl_reg[CTRL_FEAT2] |=> undef && !src_valid)
    else $error("missing feature did not give undefined");
  a_undef_wide: assert property (accept && ctrl_reg[CTRL_FEAT2] && cmd.form == MVD_IDX4 && cmd.sz &&
                                 !ctrl_reg[CTRL_WIDE] |=> undef && !trap)
    else $error("wide indexed form not undefined");
  a_trap_disabled: assert property (accept && !bad_feat && bad_en |=> trap && !src_valid ##1 !trap)
    else $error("disabled unit did not trap once");
  a_vsel_number: assert property (src_valid |-> src.gpr_idx[4:2] == VSEL_PREFIX &&
                                  src.gpr_idx[1:0] == cmd_reg.rv)
    else $error("bad select register number");
  a_single_wrap: assert property (src_valid && cmd_reg.form == MVD_SINGLE |->
                                  src.n_idx == 5'(cmd_reg.zn + 5'(r_reg)))
    else $error("single form first source not consecutive");
  a_single_low: assert property (src_valid && cmd_reg.form != MVD_MULTI |-> !src.m_idx[4])
    else $error("second source above register 15");
  a_multi_pair: assert property (src_valid && cmd_reg.form == MVD_MULTI && cmd_reg.four_grp |->
                                 src.n_idx[1:0] == r_reg && src.m_idx[1:0] == r_reg)
    else $error("group members misaligned");
  a_stride_step: assert property (take && r_reg != last_r |=> vec_reg == VW'($past(cur_vec) + $past(vstride))
                                  && r_reg == $past(r_reg) + 2'h1)
    else $error("vector index did not advance by stride");
  a_acc_write: assert property (take |=> za_reg[$past(cur_vec)] == $past(acc_new))
    else $error("accumulator not written back");
  a_group_count: assert property (take && r_reg == last_r |=> done && cmd_ready && !src_valid)
    else $error("group did not finish at last register");
  a_start_vec: assert property (take && r_reg == 2'h0 |-> cur_vec < vstride)
    else $error("start vector outside first stride");

  c_multi_x4: cover property (take && r_reg == 2'h3 && cmd_reg.form == MVD_MULTI);
  c_idx4_wide: cover property (take && cmd_reg.form == MVD_IDX4 && cmd_reg.sz);
  c_trap_seen: cover property (trap);
endmodule

// ### verification/mvd_partner.sv
// Partner model: operand fetch side of the issue pipeline
`timescale 1ns/100ps
module mvd_partner #(
  parameter int VL = mvd_pkg::VL_DEF
) (
  // Clock, reset and answer delay
  input  wire logic              clk,
  input  wire logic              reset,
  input  wire logic [3:0]        delay,
  // Fetch handshake
  input  wire logic              src_valid,
  input  wire mvd_pkg::mvd_src_t src,
  output logic                   src_ack,
  output logic [VL-1:0]          src_op1,
  output logic [VL-1:0]          src_op2,
  output logic [31:0]            src_wv
);
  import mvd_pkg::*;
  logic [VL-1:0] vec_file [32];
  logic [31:0]   gpr_file [4];
  logic [3:0]    wait_reg;
  logic          hit;

  // Answer once the delay has run; the ack cycle itself blocks a second answer
  assign hit = src_valid && !src_ack && (wait_reg >= delay);
  always_ff @(posedge clk) begin
    if (reset || !src_valid || src_ack) begin
      wait_reg <= 4'h0;
    end else if (!hit) begin
      wait_reg <= wait_reg + 4'h1;
    end
  end

  // Ack is a single-cycle pulse
  always_ff @(posedge clk) begin
    src_ack <= !reset && hit;
  end

  // Data only means something with ack; it toggles otherwise so stale values never pass
  always_ff @(posedge clk) begin
    if (hit && !reset) begin
      src_op1 <= vec_file[src.n_idx];
      src_op2 <= vec_file[src.m_idx];
      src_wv  <= (src.gpr_idx[4:2] == VSEL_PREFIX) ? gpr_file[src.gpr_idx[1:0]] : 32'h5A5A_5A5A;
    end else begin
      src_op1 <= ~src_op1;
      src_op2 <= ~src_op2;
      src_wv  <= ~src_wv;
    end
  end
endmodule

// ### verification/tb.sv
// Testbench: unsigned dot-accumulate unit against its fetch partner
`timescale 1ns/100ps
module tb;
  import mvd_pkg::*;
  localparam int NV = VL_DEF / ACC_DIV;
  logic              clk, reset, psel, penable, pwrite, pready, pslverr;
  logic [AW-1:0]     paddr;
  logic [31:0]       pwdata, prdata, src_wv;
  logic              cmd_valid, cmd_ready, src_valid, src_ack, done, undef, trap;
  logic [3:0]        delay;
  mvd_cmd_t          cmd;
  mvd_src_t          src;
  logic [VL_DEF-1:0] src_op1, src_op2;
  logic [VL_DEF-1:0] za [NV];
  int                miscompares, num_checks;

  mvd_dot_acc #(.VL(VL_DEF)) i_mvd_dot_acc (
    .clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .cmd_valid(cmd_valid),
    .cmd(cmd), .cmd_ready(cmd_ready), .src_valid(src_valid), .src(src), .src_ack(src_ack),
    .src_op1(src_op1), .src_op2(src_op2), .src_wv(src_wv), .done(done), .undef(undef), .trap(trap)
  );
  mvd_partner #(.VL(VL_DEF)) i_mvd_partner (
    .clk(clk), .reset(reset), .delay(delay), .src_valid(src_valid), .src(src), .src_ack(src_ack),
    .src_op1(src_op1), .src_op2(src_op2), .src_wv(src_wv)
  );

  // Core clock, 4 ns period
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Word comparison
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One APB transfer; pready, read data and error are all taken at the edge that samples pready high,
  // and an idle edge follows so psel is never set twice in one step
  task automatic apb(input logic wr, input logic [AW-1:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    int n;
    n = 0;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 40);
    if (n >= 40) miscompares++;
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [AW-1:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, d, q, e);
  endtask

  task automatic rd_chk(input logic [AW-1:0] a, input logic [31:0] exp, input logic err);
    logic [31:0] q;
    logic        e;
    apb(1'b0, a, 32'h0, q, e);
    chk(q, exp);
    chk({31'h0, e}, {31'h0, err});
  endtask

  // Reads every accumulator word; the first sweep clears the model, since reset leaves the array at zero
  task automatic sweep(input bit snap);
    logic [31:0] q;
    logic        e;
    for (int v = 0; v < NV; v++) begin
      for (int w = 0; w < VL_DEF / 32; w++) begin
        wr(OFF_RSEL, 32'(w << RSEL_WORD | v));
        apb(1'b0, OFF_RDAT, 32'h0, q, e);
        if (snap) za[v][w*32+:32] = 32'h0;
        chk(q, za[v][w*32+:32]);
      end
    end
  endtask

  function automatic mvd_cmd_t mk(mvd_form_t f, int g, int s, int n, int m, int r, int o, int x);
    return '{f, 1'(g), 1'(s), 5'(n), 4'(m), 2'(r), 3'(o), 2'(x)};
  endfunction

  // Reference dot product; the sum wraps to the element width
  function automatic logic [127:0] dot(logic [127:0] acc, logic [127:0] a, logic [127:0] b,
                                       int es, int way, int ixd, int ix);
    logic [63:0] sum, msk, sm, e1, e2;
    int          s, sw;
    sw  = es / way;
    msk = (es == 64) ? 64'hFFFF_FFFF_FFFF_FFFF : 64'h0000_0000_FFFF_FFFF;
    sm  = (64'h1 << sw) - 64'h1;
    for (int e = 0; e < 128 / es; e++) begin
      s   = (ixd != 0) ? e - e % (128 / es) + ix : e;
      sum = 64'(acc >> (e * es)) & msk;
      for (int i = 0; i < way; i++) begin
        e1  = 64'(a >> (e * es + i * sw)) & sm;
        e2  = 64'(b >> (s * es + i * sw)) & sm;
        sum = sum + e1 * e2;
      end
      acc = (acc & ~({64'h0, msk} << (e * es))) | ({64'h0, sum & msk} << (e * es));
    end
    return acc;
  endfunction

  // Predicts, issues, waits for the completion event, then checks the whole array
  task automatic run_op(input mvd_cmd_t c, input logic [31:0] ev_exp);
    int         nreg, str, vec, es, way, ixd, ix, nn, mm, n;
    logic [2:0] ev;
    nreg = c.four_grp ? 4 : 2;
    str  = NV / nreg;
    vec  = int'((33'(i_mvd_partner.gpr_file[c.rv]) + 33'(c.vector_offset_field)) % 33'(str));
    es   = (c.form == MVD_IDX4 && c.sz) ? 64 : 32;
    way  = (c.form == MVD_IDX4) ? 4 : 2;
    ixd  = int'(c.form[1]);
    ix   = (es == 64) ? int'(c.idx[0]) : int'(c.idx);
    for (int r = 0; r < nreg; r++) begin
      nn = (c.form == MVD_SINGLE) ? (c.zn + r) % 32 : (c.four_grp ? c.zn[2:0] * 4 : c.zn[3:0] * 2) + r;
      mm = (c.form == MVD_MULTI) ? (c.four_grp ? c.zm[2:0] * 4 : c.zm * 2) + r : int'(c.zm);
      if (ev_exp == 32'h1)
        za[vec] = dot(za[vec], i_mvd_partner.vec_file[nn], i_mvd_partner.vec_file[mm], es, way, ixd, ix);
      vec += str;
    end
    n  = 0;
    ev = 3'h0;
    cmd_valid <= 1'b1;
    cmd       <= c;
    // The command is taken at the edge that samples cmd_ready high; events are one-cycle pulses
    do begin
      @(posedge clk);
      n++;
    end while (cmd_ready !== 1'b1 && n < 40);
    cmd_valid <= 1'b0;
    while (ev == 3'h0 && n < 400) begin
      @(posedge clk);
      n++;
      ev = {trap, undef, done};
    end
    chk({29'h0, ev}, ev_exp);
    sweep(1'b0);
  endtask

  task automatic t_regs;
    rd_chk(OFF_CTRL, 32'(CTRL_RST), 1'b0);
    rd_chk(OFF_STAT, 32'h0, 1'b0);
    rd_chk(8'h10, 32'h0, 1'b1);
    wr(8'h10, 32'hFFFF_FFFF);
    wr(OFF_CTRL, 32'hF);
    rd_chk(OFF_CTRL, 32'hF, 1'b0);
    $display("test t_regs done");
  endtask

  task automatic t_refuse;
    wr(OFF_CTRL, 32'h0);
    run_op(mk(MVD_SINGLE, 0, 0, 1, 2, 0, 0, 0), 32'h2);
    rd_chk(OFF_STAT, 32'h2, 1'b0);
    wr(OFF_STAT, 32'h2);
    rd_chk(OFF_STAT, 32'h0, 1'b0);
    wr(OFF_CTRL, 32'h1);
    run_op(mk(MVD_IDX4, 1, 1, 4, 2, 0, 0, 1), 32'h2);
    run_op(mk(MVD_MULTI, 0, 0, 1, 2, 0, 0, 0), 32'h4);
    wr(OFF_CTRL, 32'h5);
    run_op(mk(MVD_SINGLE, 1, 0, 1, 2, 0, 0, 0), 32'h4);
    rd_chk(OFF_STAT, 32'h6, 1'b0);
    wr(OFF_STAT, 32'h6);
    wr(OFF_CTRL, 32'hF);
    $display("test t_refuse done");
  endtask

  // Slow partner on the second one: four groups, wrap of the first source number
  task automatic t_single;
    run_op(mk(MVD_SINGLE, 0, 0, 3, 15, 1, 7, 0), 32'h1);
    delay <= 4'h3;
    run_op(mk(MVD_SINGLE, 1, 0, 30, 4, 0, 5, 0), 32'h1);
    delay <= 4'h0;
    $display("test t_single done");
  endtask

  task automatic t_multi;
    run_op(mk(MVD_MULTI, 0, 0, 13, 6, 2, 3, 0), 32'h1);
    run_op(mk(MVD_MULTI, 1, 0, 7, 3, 3, 6, 0), 32'h1);
    $display("test t_multi done");
  endtask

  task automatic t_indexed;
    run_op(mk(MVD_IDX2, 1, 0, 2, 9, 1, 1, 3), 32'h1);
    run_op(mk(MVD_IDX4, 0, 0, 9, 11, 2, 4, 1), 32'h1);
    run_op(mk(MVD_IDX4, 1, 1, 5, 14, 3, 2, 3), 32'h1);
    $display("test t_indexed done");
  endtask

  task automatic summarize;
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Main sequence; source values are large so sums overflow
  initial begin
    reset       = 1'b1;
    psel        = 1'b0;
    penable     = 1'b0;
    pwrite      = 1'b0;
    paddr       = '0;
    pwdata      = 32'h0;
    cmd_valid   = 1'b0;
    cmd         = '0;
    delay       = 4'h0;
    miscompares = 0;
    num_checks  = 0;
    for (int i = 0; i < 32; i++) begin
      for (int w = 0; w < VL_DEF / 32; w++) begin
        i_mvd_partner.vec_file[i][w*32+:32] = 32'(i * 4 + w + 1) * 32'h9E37_79B9;
      end
    end
    i_mvd_partner.gpr_file = '{32'h0000_0002, 32'hFFFF_FFFD, 32'h7FFF_FFFF, 32'h0000_0009};
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    t_regs();
    sweep(1'b1);
    t_refuse();
    t_single();
    t_multi();
    t_indexed();
    summarize();
  end

  // Watchdog, well beyond the expected run length
  initial begin
    repeat (60000) @(posedge clk);
    miscompares++;
    summarize();
  end
endmodule
